//--- logic/mdarc_pkg.sv
/*
  Types of the multimode DRAM access and refresh controller: modes,
  sequencer states, pin groups and the core state record.
  Assumes nothing beyond the constants header.
*/
package mdarc_pkg;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_EXT_REFRESH    = 3'b000,
    MODE_FORCED_REFRESH = 3'b001,
    MODE_BURST_REFRESH  = 3'b010,
    MODE_ALL_RAS        = 3'b011,
    MODE_EXT_ACCESS     = 3'b100,
    MODE_AUTO_SLOW      = 3'b101,
    MODE_AUTO_FAST      = 3'b110,
    MODE_SET_EOC        = 3'b111
  } mdarc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RF_LOW  = 3'b001,
    ST_RF_HIGH = 3'b010,
    ST_ROW     = 3'b011,
    ST_COL     = 3'b100,
    ST_CAS     = 3'b101
  } mdarc_state_t;

  // ****************************************************************
  // Pin groups
  // ****************************************************************
  typedef struct packed {
    logic [8:0] row_addr;
    logic [8:0] col_addr;
    logic       bank_sel_hi;
    logic       bank_sel_lo;
    logic       mode_sel_hi;
    logic       mode_sel_mid;
    logic       mode_sel_lo;
    logic       addr_latch_strobe;
    logic       row_strobe_in;
    logic       col_strobe_in;
    logic       row_col_sel;
    logic       write_enable_in;
    logic       chip_sel_n;
    logic       refresh_flag_in;
  } mdarc_pins_in_t;

  typedef struct packed {
    logic [8:0] mux_addr_out;
    logic       mux_addr_oe;
    logic [3:0] ras_n;
    logic       cas_n;
    logic       we_n;
    logic       ctrl_oe;
    logic       refresh_flag_out;
    logic       refresh_flag_oe;
  } mdarc_pins_out_t;

  // ****************************************************************
  // Core state
  // ****************************************************************
  typedef struct packed {
    mdarc_state_t    st;
    logic [2:0]      tmr;
    logic [8:0]      row_lat;
    logic [8:0]      col_lat;
    logic [1:0]      bank_lat;
    logic [8:0]      cnt;
    logic [1:0]      eoc_sel;
    logic            auto_init;
    logic            req;
    logic            hidden_done;
    logic            burst_done;
    logic [2:0]      oe_hist;
    mdarc_pins_in_t  prev;
    mdarc_pins_out_t out;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [15:0]     ref_cycles;
  } mdarc_core_t;

endpackage

//--- logic/mdarc_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  multimode DRAM access and refresh controller.
  Assumes a 125 MHz pclk and a 12-bit APB byte address.
*/
`ifndef MDARC_REGS_SVH
`define MDARC_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MDARC_ADDR_W          12
`define MDARC_OFF_CTRL        12'h000
`define MDARC_OFF_STATUS      12'h004
`define MDARC_OFF_REFCNT      12'h008

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define MDARC_CTRL_EOC_LSB    0
`define MDARC_CTRL_EOC_MSB    1
`define MDARC_CTRL_CLR_BIT    2
`define MDARC_CTRL_AUTO_BIT   3
`define MDARC_EOC_SEL_RST     2'h0
`define MDARC_EOC_127         9'h07F
`define MDARC_EOC_255         9'h0FF
`define MDARC_EOC_511         9'h1FF

// ****************************************************************
// Timing
// ****************************************************************
`define MDARC_CLK_NS          8
`define MDARC_ROW_ADDR_HOLD_TIME_SLOW_NS    30
`define MDARC_ROW_ADDR_HOLD_TIME_FAST_NS    20
`define MDARC_ROW_ADDR_HOLD_TIME_SLOW_CYC   ((`MDARC_ROW_ADDR_HOLD_TIME_SLOW_NS + `MDARC_CLK_NS - 1) / `MDARC_CLK_NS)
`define MDARC_ROW_ADDR_HOLD_TIME_FAST_CYC   ((`MDARC_ROW_ADDR_HOLD_TIME_FAST_NS + `MDARC_CLK_NS - 1) / `MDARC_CLK_NS)

`endif

//--- logic/mdarc_sync.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes each bit is a level; wide buses must be stable when sampled.
*/
`timescale 1ns/1ns
module mdarc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mdarc_sync_t;

  mdarc_sync_t r;
  mdarc_sync_t next_r;

  // First stage feeds only the second stage
  always_comb
  begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  // Inactive pins sit high, so reset to ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '1;
    else
      r <= next_r;
  end

  assign dout = r.s2;

endmodule

//--- logic/mdarc_top.sv
/*
  Control logic of a multimode DRAM controller: address latches,
  refresh counter, mode decode, automatic access and refresh
  sequencing, APB status and control.
  Assumes asynchronous pins, synchronised here, and APB on pclk.
*/
`timescale 1ns/1ns
`include "mdarc_regs.svh"

// Function
// RL1: Row latch, column latch, 9-bit refresh counter
// RL2: Three mode pins select eight modes
// RL3: Access modes: bank pins pick one RAS
// RL4: Access drives row or column latch out
// RL5: Refresh: counter out, all RAS, no CAS
// RL6: Auto CAS only after column address valid
// RL7: Auto access: RAS, row-to-column, then CAS
// RL8: Auto access row hold 30 or 20 ns
// RL9: Write strobe follows write enable always; code holds it high while deselected and not refreshing
// RL10: End of count 127/255/511 pulls flag low
// RL11: Flag pin pulled low clears counter
// RL12: Latches transparent while strobe high
// RL13: Deselected: address floats, controls weak high; code keeps driving them while a refresh is running
// RL14: Reset: counter zero, controls high, eoc 127
// RL15: Mode 0 external refresh, 4 external access
// RL16: Mode 5 hidden refresh, else request forced
// RL17: Mode 1 refreshes only after acknowledge
// RL18: Mode 2 bursts refreshes until end count
// RL19: All-RAS init, external or clocked
// RL20: Mode 7 loads end count from bank pins
// RL21: Mode code table 000 through 111
// RL22: Row strobe: one bank or all banks
// RL23: External CAS from select and column strobe
// RL24: Forced refresh mode flag is request
// RL25: Counter steps per refresh, wraps at end
module mdarc_top
  import mdarc_pkg::*;
(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`MDARC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // DRAM side and system pins
  input  wire mdarc_pins_in_t           dram_in,
  output mdarc_pins_out_t               dram_out
);

  localparam logic [2:0] HOLD_SLOW = 3'(`MDARC_ROW_ADDR_HOLD_TIME_SLOW_CYC);
  localparam logic [2:0] HOLD_FAST = 3'(`MDARC_ROW_ADDR_HOLD_TIME_FAST_CYC);
  // Reset ones decode as all-bank mode, not an end-count load, see RL14
  localparam mdarc_pins_in_t SYNC_INV = '{mode_sel_hi: 1'b1, default: '0};

  localparam mdarc_core_t CORE_RST = '{
    st: ST_IDLE, tmr: 3'h0, row_lat: 9'h000, col_lat: 9'h000, bank_lat: 2'h0,
    cnt: 9'h000, eoc_sel: `MDARC_EOC_SEL_RST, auto_init: 1'b0, req: 1'b0,
    hidden_done: 1'b0, burst_done: 1'b0, oe_hist: 3'h0, prev: '1,
    out: '{mux_addr_out: 9'h000, mux_addr_oe: 1'b0, ras_n: 4'hF, cas_n: 1'b1,
           we_n: 1'b1, ctrl_oe: 1'b0, refresh_flag_out: 1'b0, refresh_flag_oe: 1'b0},
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, ref_cycles: 16'h0000};

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [8:0] eoc_value(input logic [1:0] sel);
    case (sel)
      2'h0:    eoc_value = `MDARC_EOC_127;
      2'h1:    eoc_value = `MDARC_EOC_255;
      default: eoc_value = `MDARC_EOC_511;
    endcase
  endfunction

  function automatic logic [3:0] bank_ras_n(input logic [1:0] bank);
    bank_ras_n = ~(4'h1 << bank);
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  mdarc_pins_in_t d;
  mdarc_pins_in_t d_sync;
  mdarc_core_t    r;
  mdarc_core_t    next_r;

  mdarc_sync #(.W($bits(mdarc_pins_in_t))) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (dram_in ^ SYNC_INV),
    .dout    (d_sync)
  );

  assign d = d_sync ^ SYNC_INV;

  mdarc_mode_t mode;
  mdarc_mode_t mode_prev;
  logic [8:0]  eoc;
  logic        at_eoc;
  logic        row_strobe_in_rise;
  logic        row_strobe_in_fall;
  logic        gclk_rise;
  logic        period_rise;
  logic        ext_rst;
  logic        apb_setup;
  logic        apb_done;
  logic        hit;
  logic [31:0] rd;

  // Mode pins decode straight into the mode code, see RL2 and RL21
  assign mode        = mdarc_mode_t'({d.mode_sel_hi, d.mode_sel_mid, d.mode_sel_lo});
  assign mode_prev   = mdarc_mode_t'({r.prev.mode_sel_hi, r.prev.mode_sel_mid,
                                      r.prev.mode_sel_lo});
  assign eoc         = eoc_value(r.eoc_sel);
  assign at_eoc      = (r.cnt == eoc);
  assign row_strobe_in_rise  = d.row_strobe_in & ~r.prev.row_strobe_in;
  assign row_strobe_in_fall  = ~d.row_strobe_in & r.prev.row_strobe_in;
  assign gclk_rise   = d.col_strobe_in & ~r.prev.col_strobe_in;
  assign period_rise = d.row_col_sel & ~r.prev.row_col_sel;
  // Own drive takes three cycles to leave the synchroniser, see RL11
  assign ext_rst     = ~d.refresh_flag_in & ~r.out.refresh_flag_oe & ~(|r.oe_hist);
  assign apb_setup   = psel & penable & ~r.pready;
  assign apb_done    = psel & penable & r.pready;

  // ****************************************************************
  // APB read decode
  // ****************************************************************
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      `MDARC_OFF_CTRL:   rd = {28'h0000000, r.auto_init, 1'b0, r.eoc_sel};
      `MDARC_OFF_STATUS: rd = {14'h0000, r.st, mode, r.hidden_done, r.req, at_eoc, r.cnt};
      `MDARC_OFF_REFCNT: rd = {16'h0000, r.ref_cycles};
      default:
      begin
        hit = 1'b0;
        rd  = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // Core next state
  // ****************************************************************
  logic       inc;
  logic       refr;
  logic       flag_low;
  logic       req_set;
  logic       req_clr;
  logic       sw_clr;
  logic       hid_set;
  logic       auto_on;
  logic       auto_trig;
  logic       auto_fin;
  logic       auto_abort;
  logic       cs_act;
  logic [2:0] auto_hold;
  logic [3:0] auto_mask;
  logic [3:0] ras;
  logic       cas;
  logic [8:0] addr;

  always_comb
  begin
    next_r     = r;
    inc        = 1'b0;
    refr       = 1'b0;
    flag_low   = 1'b0;
    req_set    = 1'b0;
    req_clr    = 1'b0;
    sw_clr     = 1'b0;
    hid_set    = 1'b0;
    auto_on    = 1'b0;
    auto_trig  = 1'b0;
    auto_fin   = 1'b0;
    auto_abort = 1'b0;
    auto_hold  = HOLD_FAST;
    auto_mask  = 4'h0;
    ras        = 4'hF;
    cas        = 1'b1;
    // Access address follows the select pin, see RL4
    addr       = d.row_col_sel ? r.row_lat : r.col_lat;
    next_r.prev = d;
    // Latches follow the inputs while the strobe is high, see RL1 and RL12
    if (d.addr_latch_strobe)
    begin
      next_r.row_lat  = d.row_addr;
      next_r.col_lat  = d.col_addr;
      next_r.bank_lat = {d.bank_sel_hi, d.bank_sel_lo};
    end
    case (mode)
      MODE_EXT_REFRESH:
      begin
        // Refresh drives the counter to all banks, see RL5, RL15 and RL22
        addr     = r.cnt;
        ras      = {4{d.row_strobe_in}};
        refr     = ~d.row_strobe_in;
        inc      = row_strobe_in_rise;
        flag_low = at_eoc;
      end
      MODE_FORCED_REFRESH, MODE_BURST_REFRESH:
      begin
        addr = r.cnt;
        refr = (r.st != ST_IDLE);
        case (r.st)
          ST_IDLE:
          begin
            // Forced refresh waits for the acknowledged request, see RL17
            if (gclk_rise && (mode == MODE_FORCED_REFRESH ? r.req : ~r.burst_done))
              next_r.st = ST_RF_LOW;
          end
          ST_RF_LOW:
          begin
            ras = 4'h0;
            if (gclk_rise)
            begin
              next_r.st = ST_RF_HIGH;
              inc       = 1'b1;
            end
          end
          ST_RF_HIGH:
          begin
            if (gclk_rise)
              next_r.st = ST_IDLE;
          end
          default: next_r.st = ST_IDLE;
        endcase
        if (mode == MODE_BURST_REFRESH)
        begin
          // Burst stops once the end count has been refreshed, see RL18
          flag_low = at_eoc;
          if (inc && at_eoc)
            next_r.burst_done = 1'b1;
        end
        else
        begin
          // Flag pin carries the request here, see RL24
          flag_low = r.req;
          req_clr  = inc;
        end
      end
      MODE_ALL_RAS:
      begin
        // Initialisation runs on every bank, see RL19
        if (r.auto_init)
        begin
          auto_on   = 1'b1;
          auto_trig = gclk_rise;
          auto_fin  = gclk_rise;
          flag_low  = at_eoc;
        end
        else
        begin
          ras = {4{d.row_strobe_in}};
          cas = d.row_col_sel | d.col_strobe_in;
        end
      end
      MODE_EXT_ACCESS:
      begin
        // One bank, CAS gated by the select and the strobe, see RL3 and RL23
        ras = d.row_strobe_in ? 4'hF : bank_ras_n(r.bank_lat);
        cas = d.row_col_sel | d.col_strobe_in;
      end
      MODE_AUTO_SLOW, MODE_AUTO_FAST:
      begin
        if (mode == MODE_AUTO_SLOW && d.chip_sel_n)
        begin
          // Refresh hidden behind a deselected access, see RL16
          addr    = r.cnt;
          ras     = {4{d.row_strobe_in}};
          refr    = ~d.row_strobe_in;
          inc     = row_strobe_in_rise;
          hid_set = row_strobe_in_rise;
        end
        else
        begin
          auto_on    = 1'b1;
          auto_mask  = ~bank_ras_n(r.bank_lat);
          auto_hold  = (mode == MODE_AUTO_SLOW) ? HOLD_SLOW : HOLD_FAST;
          auto_trig  = row_strobe_in_fall;
          auto_abort = d.row_strobe_in;
          // A low column strobe stretches CAS in the fast mode
          auto_fin   = d.row_strobe_in & (d.col_strobe_in | (mode == MODE_AUTO_SLOW));
        end
        if (mode == MODE_AUTO_SLOW)
        begin
          flag_low = r.req;
          if (period_rise)
            req_set = ~r.hidden_done;
        end
      end
      MODE_SET_EOC:
      begin
        // End count taken from the bank pins, see RL20
        next_r.eoc_sel = {d.bank_sel_hi, d.bank_sel_lo};
      end
      default: ;
    endcase
    // Automatic sequence: RAS, row hold, column, then CAS, see RL7 and RL8
    if (auto_on)
    begin
      if (auto_mask == 4'h0)
        auto_mask = 4'hF;
      case (r.st)
        ST_IDLE:
        begin
          addr = r.row_lat;
          if (auto_trig)
          begin
            next_r.st  = ST_ROW;
            next_r.tmr = auto_hold - 3'h1;
          end
        end
        ST_ROW:
        begin
          ras  = ~auto_mask;
          addr = r.row_lat;
          if (auto_abort)
            next_r.st = ST_IDLE;
          else if (r.tmr == 3'h0)
            next_r.st = ST_COL;
          else
            next_r.tmr = r.tmr - 3'h1;
        end
        ST_COL:
        begin
          ras       = ~auto_mask;
          addr      = r.col_lat;
          next_r.st = auto_abort ? ST_IDLE : ST_CAS;
        end
        ST_CAS:
        begin
          // Column address was already out a cycle earlier, see RL6
          ras  = d.row_strobe_in && mode != MODE_ALL_RAS ? 4'hF : ~auto_mask;
          addr = r.col_lat;
          cas  = 1'b0;
          if (auto_fin)
          begin
            next_r.st = ST_IDLE;
            inc       = (mode == MODE_ALL_RAS);
          end
        end
        default: next_r.st = ST_IDLE;
      endcase
    end
    if (mode != mode_prev)
      next_r.st = ST_IDLE;
    if (mode != MODE_BURST_REFRESH)
      next_r.burst_done = 1'b0;
    // A period edge restarts the hidden refresh watch, a refresh wins
    if (mode == MODE_AUTO_SLOW && period_rise)
      next_r.hidden_done = hid_set;
    else if (hid_set)
      next_r.hidden_done = 1'b1;
    next_r.req = req_set | (r.req & ~req_clr);
    // APB: answer one cycle into the access phase, act on the ready edge
    next_r.pready  = apb_setup;
    next_r.pslverr = apb_setup & ~hit;
    if (apb_setup && !pwrite)
      next_r.prdata = rd;
    if (apb_done && pwrite && paddr == `MDARC_OFF_CTRL && pstrb[0] && mode != MODE_SET_EOC)
    begin
      next_r.eoc_sel   = pwdata[`MDARC_CTRL_EOC_MSB:`MDARC_CTRL_EOC_LSB];
      next_r.auto_init = pwdata[`MDARC_CTRL_AUTO_BIT];
      sw_clr           = pwdata[`MDARC_CTRL_CLR_BIT];
    end
    // Counter clears on the pin or software, else steps and wraps, see RL11 and RL25
    if (ext_rst || sw_clr)
      next_r.cnt = 9'h000;
    else if (inc)
      next_r.cnt = at_eoc ? 9'h000 : r.cnt + 9'h001;
    if (inc)
      next_r.ref_cycles = r.ref_cycles + 16'h0001;
    // Deselect floats the address, controls held weakly high, unless a refresh is running, see RL13
    cs_act = ~d.chip_sel_n | refr;
    next_r.out.mux_addr_out     = addr;
    next_r.out.mux_addr_oe      = cs_act;
    next_r.out.ctrl_oe          = cs_act;
    next_r.out.ras_n            = cs_act ? ras : 4'hF;
    next_r.out.cas_n            = cs_act ? cas : 1'b1;
    // Write strobe copies the input while selected or refreshing, held high otherwise, see RL9
    next_r.out.we_n             = cs_act ? d.write_enable_in : 1'b1;
    // End count or request pulls the open-drain flag low, see RL10
    next_r.out.refresh_flag_out = 1'b0;
    next_r.out.refresh_flag_oe  = flag_low;
    next_r.oe_hist              = {r.oe_hist[1:0], r.out.refresh_flag_oe};
  end

  // Reset state holds controls high and end count 127, see RL14
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= CORE_RST;
    else
      r <= next_r;
  end

  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign dram_out = r.out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic in_row;
  assign in_row = (r.st == ST_ROW);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_we_follow: assert property (r.out.ctrl_oe |-> r.out.we_n == $past(d.write_enable_in)) // see RL9
    else $error("write strobe does not follow write enable");
  a_refresh_addr: assert property ( // see RL5
    $past(mode) == MODE_EXT_REFRESH && $past(mode_prev) == MODE_EXT_REFRESH
    |-> r.out.mux_addr_out == $past(r.cnt) && r.out.cas_n)
    else $error("refresh did not show counter or let CAS fall");
  a_all_ras_refresh: assert property ( // see RL22
    $past(mode) == MODE_EXT_REFRESH && !$past(d.row_strobe_in) |-> r.out.ras_n == 4'h0)
    else $error("refresh did not strobe every bank");
  a_one_bank: assert property ( // see RL3
    $past(mode) == MODE_EXT_ACCESS && !$past(d.row_strobe_in) && !$past(d.chip_sel_n)
    |-> $onehot(~r.out.ras_n))
    else $error("access strobed other than one bank");
  a_fast_hold: assert property ( // see RL8
    r.st == ST_COL && $past(in_row) && mode == MODE_AUTO_FAST && $past(mode) == MODE_AUTO_FAST
    |-> $past(in_row, 3))
    else $error("fast row hold shorter than three cycles");
  a_slow_hold: assert property ( // see RL8
    r.st == ST_COL && $past(in_row) && mode == MODE_AUTO_SLOW && $past(mode) == MODE_AUTO_SLOW
    |-> $past(in_row, 4))
    else $error("slow row hold shorter than four cycles");
  a_cas_after_col: assert property ( // see RL6
    $fell(r.out.cas_n) && r.st == ST_CAS |-> $past(r.out.mux_addr_out) == $past(r.col_lat))
    else $error("CAS fell before column address");
  a_eoc_flag: assert property ( // see RL10
    $past(mode) == MODE_EXT_REFRESH && $past(at_eoc)
    |-> r.out.refresh_flag_oe && !r.out.refresh_flag_out)
    else $error("end count not flagged");
  a_ext_clear: assert property (ext_rst |=> r.cnt == 9'h000) // see RL11
    else $error("flag pin low did not clear counter");
  a_eoc_load: assert property ( // see RL20
    $past(mode) == MODE_SET_EOC |-> r.eoc_sel == $past({d.bank_sel_hi, d.bank_sel_lo}))
    else $error("end count not loaded from bank pins");
  a_deselect: assert property ($past(d.chip_sel_n) && !$past(refr) |-> // see RL13
    !r.out.mux_addr_oe && !r.out.ctrl_oe && r.out.ras_n == 4'hF && r.out.cas_n && r.out.we_n)
    else $error("deselected outputs still driven");
  a_apb_ready: assert property (apb_setup |=> r.pready ##1 !r.pready)
    else $error("APB answer not one cycle long");

  c_burst_done: cover property (mode == MODE_BURST_REFRESH && $rose(r.burst_done));
  c_forced: cover property (mode == MODE_FORCED_REFRESH && $fell(r.req));
  c_auto_cas: cover property (mode == MODE_AUTO_FAST && $fell(r.out.cas_n));
  c_hidden: cover property ($rose(r.hidden_done));

endmodule

//--- sim/mdarc_sys_model.sv
/*
  System-side model: the open-drain refresh flag wire with its pull-up.
  Assumes the bench asks for the external pull-down.
*/
`timescale 1ns/1ns
module mdarc_sys_model (
  // Pull-downs
  input  wire logic dev_pull,
  input  wire logic sys_pull,
  // Wire level
  output logic      flag_level
);
  // Pull-up shows only while nobody sinks the wire
  assign flag_level = ~(dev_pull | sys_pull);
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for mdarc_top: APB, access, auto access, refresh.
  Assumes mdarc_pkg and mdarc_regs.svh are compiled first.
*/
`timescale 1ns/1ns
`include "mdarc_regs.svh"
module testbench
  import mdarc_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, sys_pull, flag, e;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, r;
  logic [3:0]      pstrb;
  logic [8:0]      row, col;
  mdarc_pins_in_t  di, dx;
  mdarc_pins_out_t dout;
  int              n_fail, check_count, cyc, m_cnt, k;

  mdarc_top mdarc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dram_in(dx), .dram_out(dout));
  mdarc_sys_model mdarc_sys_model_inst (.dev_pull(dout.refresh_flag_oe),
    .sys_pull(sys_pull), .flag_level(flag));

  always_comb
  begin
    dx = di;
    dx.refresh_flag_in = flag;
  end

  initial
  begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard: whole run needs well under this
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out;
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic close_out;
    $display("fails %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic gen(input int n);
    repeat (n)
    begin
      di.col_strobe_in <= 0;
      wt(4);
      di.col_strobe_in <= 1;
      wt(4);
    end
  endtask

  task automatic md(input logic [2:0] m);
    {di.mode_sel_hi, di.mode_sel_mid, di.mode_sel_lo} <= m;
    wt(5);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, sys_pull, n_fail, check_count, cyc} = '0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hF;
    di = '1;
    {di.mode_sel_mid, di.mode_sel_lo} = 2'h0;
    k = $urandom(70);
    wt(5);
    chk({dout.ras_n, dout.mux_addr_oe}, 5'h1E);
    presetn <= 1;
    di.chip_sel_n <= 0;
    wt(5);
    apb(0, `MDARC_OFF_STATUS, 0);
    chk(r[8:0], 0);
    apb(0, `MDARC_OFF_CTRL, 0);
    chk(r[3:0], 4'h0);
    apb(0, 12'hFFC, 0);
    chk(e, 1);
    for (int b = 0; b < 4; b++)
    begin
      row = 9'($urandom);
      col = ~row;
      {di.row_addr, di.col_addr} <= {row, col};
      {di.bank_sel_hi, di.bank_sel_lo} <= 2'(b);
      di.addr_latch_strobe <= 1;
      di.write_enable_in <= b[0];
      wt(5);
      di.addr_latch_strobe <= 0;
      wt(5);
      di.row_addr <= col;
      di.row_strobe_in <= 0;
      wt(5);
      chk(dout.mux_addr_out, row);
      chk(dout.ras_n, 4'(~(4'h1 << b)));
      chk({dout.we_n, dout.cas_n}, {b[0], 1'b1});
      di.row_col_sel <= 0;
      wt(5);
      chk(dout.mux_addr_out, col);
      di.col_strobe_in <= 0;
      wt(5);
      chk(dout.cas_n, 0);
      {di.row_strobe_in, di.col_strobe_in, di.row_col_sel} <= 3'h7;
      wt(5);
    end
    di.chip_sel_n <= 1;
    wt(5);
    chk({dout.mux_addr_oe, dout.ctrl_oe}, 0);
    di.chip_sel_n <= 0;
    for (int m = 5; m < 7; m++)
    begin
      md(3'(m));
      di.row_strobe_in <= 0;
      for (k = 0; k < 20 && dout.ras_n === 4'hF; k++)
        @(posedge pclk);
      for (k = 0; k < 20 && dout.mux_addr_out === row; k++)
        @(posedge pclk);
      chk(32'(k >= (m == 5 ? `MDARC_ROW_ADDR_HOLD_TIME_SLOW_CYC : `MDARC_ROW_ADDR_HOLD_TIME_FAST_CYC)), 1);
      for (k = 0; k < 20 && dout.cas_n !== 1'b0; k++)
        @(posedge pclk);
      chk({dout.ras_n, dout.mux_addr_out}, {4'h7, col});
      di.row_strobe_in <= 1;
      wt(5);
    end
    {di.bank_sel_hi, di.bank_sel_lo} <= 2'h1;
    md(3'h7);
    md(3'h0);
    apb(0, `MDARC_OFF_CTRL, 0);
    chk(r[1:0], 1);
    apb(1, `MDARC_OFF_CTRL, 32'h4);
    m_cnt = 0;
    // Runs past 127 so the wrap back to zero is seen
    for (int i = 0; i < 130; i++)
    begin
      di.row_strobe_in <= 0;
      wt(5);
      chk({dout.ras_n, dout.cas_n, dout.mux_addr_out}, {5'h1, 9'(m_cnt)});
      di.row_strobe_in <= 1;
      wt(5);
      m_cnt = (m_cnt + 1) % 128;
      chk(dout.refresh_flag_oe, m_cnt == 127);
    end
    sys_pull <= 1;
    wt(5);
    sys_pull <= 0;
    wt(5);
    apb(0, `MDARC_OFF_STATUS, 0);
    chk(r[8:0], 0);
    // Period edge with no hidden refresh raises the request
    md(3'h5);
    di.row_col_sel <= 0;
    wt(5);
    di.row_col_sel <= 1;
    wt(5);
    chk(dout.refresh_flag_oe, 1);
    // Entering mode 1 is the system's acknowledge
    md(3'h1);
    gen(3);
    apb(0, `MDARC_OFF_STATUS, 0);
    chk(r[10:0], 11'h001);
    // Burst from count 1: three gen edges per refresh, must stop after 127
    md(3'h2);
    gen(400);
    apb(0, `MDARC_OFF_REFCNT, 0);
    // 130 external, 1 forced, 127 burst refreshes
    chk(r, 32'h102);
    md(3'h3);
    di.row_strobe_in <= 0;
    wt(5);
    chk(dout.ras_n, 4'h0);
    close_out;
  end
endmodule
